// file: verilog/vic_pkg.sv
// What this block does
// - Thirty-two request sources, each with a fixed vector 8 bytes apart.
// - Servicing a source forces a long call to that source's vector.
// - Fixed priority 0 to 32; hardware reset source is rank 0, unmaskable.
// - Maskable sources are taken only while the global enable bit is 1.
// - Each maskable source also needs its own bit in one of six enable banks.
// - A request sets its flag, held until accepted, then cleared by hardware.
// - A latched request is held until accepted, reset or cleared by a write.
// - Acceptance happens only in the last cycle of the current instruction.
// - On acceptance the next fetch is suppressed and a call pushes the PC.
// - During the forced call the accepted source's vector is presented.
// - Entry into the service routine always takes 5 machine cycles.
// - Service ends only when the core executes the interrupt return.
// - Bank 5 resets to 00H; bits 7:6 read-only, bits 5:0 read-write; only bits 1:0 enable sources (30, 31).
package vic_pkg;

  // ----------------------------------------------------------------------
  // Sizes and source map
  // ----------------------------------------------------------------------
  localparam int NUM_SRC = 32;
  localparam int NUM_BANK = 6;
  localparam int BANK_BITS = 6;
  // Sources 5 and 23 to 27 are reserved slots.
  localparam logic [31:0] IMPL_MASK = 32'hF07F_FFDF;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_EN_BANK_0 = 8'hA8;
  localparam logic [7:0] OFS_EN_BANK_5 = 8'hAD;
  localparam logic [7:0] OFS_GLOBAL_EN = 8'hAE;
  localparam logic [7:0] OFS_PEND_0 = 8'hB0;
  localparam logic [7:0] OFS_PEND_3 = 8'hB3;
  localparam logic [7:0] OFS_EVT_STATUS = 8'hB4;
  localparam logic [7:0] OFS_EVT_MASK = 8'hB5;
  localparam logic [7:0] OFS_ACTIVE_SRC = 8'hB6;
  localparam logic [7:0] OFS_VEC_LO = 8'hB7;
  localparam logic [7:0] OFS_VEC_HI = 8'hB8;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [5:0] RST_EN_BANK = 6'h00;
  localparam logic RST_GLOBAL_EN = 1'b0;
  // The reset source is always owed one call after a reset.
  localparam logic RST_BOOT_PENDING = 1'b1;
  localparam logic [1:0] RST_EVT = 2'h0;
  localparam int EVT_ACCEPT = 0;
  localparam int EVT_RETURN = 1;

  // ----------------------------------------------------------------------
  // Vectors and timing
  // ----------------------------------------------------------------------
  localparam logic [15:0] VEC_BOOT = 16'h0000;
  localparam logic [15:0] VEC_FIRST = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  localparam logic [3:0] ENTRY_MIN_CYCLES = 4'h5;
  localparam logic [3:0] ENTRY_MAX_CYCLES = 4'h8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {VIC_IDLE, VIC_ENTRY, VIC_SERVICE} vic_fsm_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vic_bus_t;

  typedef struct packed {
    logic call_start;
    logic suppress_fetch;
    logic in_service;
    logic [15:0] vector;
  } vic_call_t;

  typedef struct packed {
    logic flag;
  } vic_flag_t;

  typedef struct packed {
    vic_fsm_t state;
    logic [3:0] entry_cnt;
    logic boot_pending;
    logic [NUM_BANK-1:0][BANK_BITS-1:0] en_bank;
    logic global_en;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    logic irq;
    logic [7:0] rdata;
    logic [5:0] active_src;
    vic_call_t call;
  } vic_regs_t;

endpackage

// file: verilog/vic_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none
module vic_flag_cell (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic set_req,
  input wire logic clear,
  // State
  output logic flag
);

  vic_pkg::vic_flag_t q;
  vic_pkg::vic_flag_t next_q;

  // A request arriving in the clearing cycle is kept: set wins.
  always_comb begin
    next_q = q;
    next_q.flag = set_req | (q.flag & ~clear);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign flag = q.flag;

endmodule
`default_nettype wire

// file: verilog/vic_prio_pick.sv
`timescale 1ns/1ps
`default_nettype none
module vic_prio_pick (
  // Candidates, bit 0 highest rank
  input wire logic [31:0] cand,
  // Winner
  output logic found,
  output logic [4:0] idx
);

  always_comb begin
    found = |cand;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (cand[i]) begin
        idx = 5'(i);
      end
    end
  end

endmodule
`default_nettype wire

// file: verilog/vic_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module vic_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire vic_pkg::vic_bus_t bus,
  output logic [7:0] reg_rdata,
  // Request lines, bit n is external source n
  input wire logic [31:0] int_req,
  // Core handshake
  input wire logic instr_last,
  input wire logic reti_exec,
  output vic_pkg::vic_call_t core_call,
  // Event interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam vic_pkg::vic_regs_t RST = '{
    state: vic_pkg::VIC_IDLE,
    entry_cnt: 4'h0,
    boot_pending: vic_pkg::RST_BOOT_PENDING,
    en_bank: {vic_pkg::NUM_BANK{vic_pkg::RST_EN_BANK}},
    global_en: vic_pkg::RST_GLOBAL_EN,
    evt_status: vic_pkg::RST_EVT,
    evt_mask: vic_pkg::RST_EVT,
    irq: 1'b0,
    rdata: 8'h00,
    active_src: 6'h00,
    call: '0
  };

  vic_pkg::vic_regs_t q;
  vic_pkg::vic_regs_t next_q;

  logic [31:0] flags;
  logic [31:0] en_vec;
  logic [31:0] cand;
  logic [31:0] sw_clear;
  logic [31:0] accept_clear;
  logic [1:0] evt;
  logic pick_found;
  logic [4:0] pick_idx;
  logic [7:0] bank_off;
  logic [2:0] bank_sel;
  logic in_bank;
  logic in_pend;

  // ----------------------------------------------------------------------
  // Request latches and arbitration
  // ----------------------------------------------------------------------
  // Reserved slots have their set input tied off here, so no write to a
  // reserved enable bit can ever make them visible.
  genvar s;
  generate
    for (s = 0; s < vic_pkg::NUM_SRC; s++) begin : g_flag
      vic_flag_cell u_flag (
        .core_clk(core_clk),
        .reset(reset),
        .set_req(int_req[s] & vic_pkg::IMPL_MASK[s]),
        .clear(sw_clear[s] | accept_clear[s]),
        .flag(flags[s])
      );
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
      // Source n sits in bank n/6, bit n%6.
      en_vec[i] = q.en_bank[i / vic_pkg::BANK_BITS][i % vic_pkg::BANK_BITS]
          & vic_pkg::IMPL_MASK[i];
    end
    cand = flags & en_vec & {32{q.global_en}};
  end

  vic_prio_pick u_pick (
    .cand(cand),
    .found(pick_found),
    .idx(pick_idx)
  );

  assign bank_off = bus.addr - vic_pkg::OFS_EN_BANK_0;
  assign bank_sel = bank_off[2:0];
  assign in_bank = (bus.addr >= vic_pkg::OFS_EN_BANK_0) && (bus.addr <= vic_pkg::OFS_EN_BANK_5);
  assign in_pend = (bus.addr >= vic_pkg::OFS_PEND_0) && (bus.addr <= vic_pkg::OFS_PEND_3);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.call.call_start = 1'b0;
    next_q.rdata = 8'h00;
    sw_clear = '0;
    accept_clear = '0;
    evt = 2'h0;

    // Writes. Bits 7:6 of each bank are not stored and read as zero.
    if (bus.wr) begin
      if (in_bank) begin
        next_q.en_bank[bank_sel] = bus.wdata[5:0];
      end
      if (in_pend) begin
        sw_clear[{bus.addr[1:0], 3'b000} +: 8] = ~bus.wdata;
      end
      case (bus.addr)
        vic_pkg::OFS_GLOBAL_EN: begin
          next_q.global_en = bus.wdata[0];
        end
        vic_pkg::OFS_EVT_MASK: begin
          next_q.evt_mask = bus.wdata[1:0];
        end
        vic_pkg::OFS_EVT_STATUS: begin
          next_q.evt_status = q.evt_status & ~bus.wdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // Reads. Data stand only in the cycle after the strobe.
    if (bus.rd) begin
      if (in_bank) begin
        next_q.rdata = {2'b00, q.en_bank[bank_sel]};
      end else if (in_pend) begin
        next_q.rdata = flags[{bus.addr[1:0], 3'b000} +: 8];
      end else begin
        case (bus.addr)
          vic_pkg::OFS_GLOBAL_EN: begin
            next_q.rdata = {7'h00, q.global_en};
          end
          vic_pkg::OFS_EVT_STATUS: begin
            next_q.rdata = {6'h00, q.evt_status};
          end
          vic_pkg::OFS_EVT_MASK: begin
            next_q.rdata = {6'h00, q.evt_mask};
          end
          vic_pkg::OFS_ACTIVE_SRC: begin
            next_q.rdata = {1'b0, q.call.in_service, q.active_src};
          end
          vic_pkg::OFS_VEC_LO: begin
            next_q.rdata = q.call.vector[7:0];
          end
          vic_pkg::OFS_VEC_HI: begin
            next_q.rdata = q.call.vector[15:8];
          end
          default: begin
            next_q.rdata = 8'h00;
          end
        endcase
      end
    end

    // Sequencer. No nesting: a new acceptance waits for the return.
    case (q.state)
      vic_pkg::VIC_IDLE: begin
        if (instr_last) begin
          if (q.boot_pending) begin
            // The reset source needs neither global nor own enable.
            next_q.boot_pending = 1'b0;
            next_q.call.vector = vic_pkg::VEC_BOOT;
            next_q.active_src = 6'h00;
            next_q.call.call_start = 1'b1;
            next_q.call.suppress_fetch = 1'b1;
            next_q.entry_cnt = vic_pkg::ENTRY_MIN_CYCLES;
            next_q.state = vic_pkg::VIC_ENTRY;
            evt[vic_pkg::EVT_ACCEPT] = 1'b1;
          end else if (pick_found) begin
            accept_clear[pick_idx] = 1'b1;
            next_q.call.vector = vic_pkg::VEC_FIRST
                + 16'(vic_pkg::VEC_STEP * {11'h000, pick_idx});
            next_q.active_src = 6'({1'b0, pick_idx} + 6'h01);
            next_q.call.call_start = 1'b1;
            next_q.call.suppress_fetch = 1'b1;
            next_q.entry_cnt = vic_pkg::ENTRY_MIN_CYCLES;
            next_q.state = vic_pkg::VIC_ENTRY;
            evt[vic_pkg::EVT_ACCEPT] = 1'b1;
          end
        end
      end
      vic_pkg::VIC_ENTRY: begin
        // Fetch stays suppressed while the call pushes the PC.
        if (q.entry_cnt <= 4'h1) begin
          next_q.entry_cnt = 4'h0;
          next_q.call.suppress_fetch = 1'b0;
          next_q.call.in_service = 1'b1;
          next_q.state = vic_pkg::VIC_SERVICE;
        end else begin
          next_q.entry_cnt = 4'(q.entry_cnt - 4'h1);
        end
      end
      vic_pkg::VIC_SERVICE: begin
        if (reti_exec) begin
          next_q.call.in_service = 1'b0;
          next_q.state = vic_pkg::VIC_IDLE;
          evt[vic_pkg::EVT_RETURN] = 1'b1;
        end
      end
      default: begin
        next_q.state = vic_pkg::VIC_IDLE;
        next_q.call.suppress_fetch = 1'b0;
        next_q.call.in_service = 1'b0;
      end
    endcase

    // Events set after the software clear so a same-cycle event survives.
    next_q.evt_status = next_q.evt_status | evt;
    next_q.irq = |(next_q.evt_status & next_q.evt_mask);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata = q.rdata;
  assign core_call = q.call;
  assign irq = q.irq;

endmodule
`default_nettype wire

// file: bench/vic_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vic_ctrl_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire vic_pkg::vic_bus_t bus,
  input wire logic [7:0] reg_rdata,
  // Requests and core handshake
  input wire logic [31:0] int_req,
  input wire logic instr_last,
  input wire logic reti_exec,
  input wire vic_pkg::vic_call_t core_call,
  input wire logic irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  property p_accept_edge;
    core_call.call_start |-> $past(instr_last) && core_call.suppress_fetch;
  endproperty
  a_accept_edge: assert property (p_accept_edge)
    else $error("call began away from an instruction end");
  property p_start_pulse;
    core_call.call_start |=> !core_call.call_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("call start longer than one cycle");
  property p_entry_len;
    $rose(core_call.suppress_fetch) |-> core_call.suppress_fetch [*5]
      ##1 (!core_call.suppress_fetch && core_call.in_service);
  endproperty
  a_entry_len: assert property (p_entry_len)
    else $error("entry time wrong");
  property p_vec_map;
    core_call.call_start |-> core_call.vector == 16'h0000 ||
      (core_call.vector[2:0] == 3'h3 && core_call.vector <= 16'h00FB);
  endproperty
  a_vec_map: assert property (p_vec_map)
    else $error("vector off the table");
  property p_vec_resv;
    core_call.call_start |-> !(core_call.vector inside {16'h002B, [16'h00BB:16'h00DB]});
  endproperty
  a_vec_resv: assert property (p_vec_resv)
    else $error("reserved slot taken");
  property p_vec_hold;
    !core_call.call_start |-> $stable(core_call.vector);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector moved without a call");
  property p_reti_end;
    core_call.in_service && reti_exec |=> !core_call.in_service;
  endproperty
  a_reti_end: assert property (p_reti_end)
    else $error("service outlived return");
  property p_svc_hold;
    core_call.in_service && !reti_exec |=> core_call.in_service;
  endproperty
  a_svc_hold: assert property (p_svc_hold)
    else $error("service ended without return");
  property p_bank_ro;
    $past(bus.rd) && $past(bus.addr) == 8'hAD |-> reg_rdata[7:6] == 2'h0;
  endproperty
  a_bank_ro: assert property (p_bank_ro)
    else $error("bank 5 top bits not zero");
endmodule

bind vic_ctrl vic_ctrl_checker u_chk (.core_clk(core_clk), .reset(reset), .bus(bus),
  .reg_rdata(reg_rdata), .int_req(int_req), .instr_last(instr_last),
  .reti_exec(reti_exec), .core_call(core_call), .irq(irq));
`default_nettype wire

// file: bench/vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Controller side
  input wire vic_pkg::vic_call_t core_call,
  // Core status
  output logic instr_last,
  output logic reti_exec
);
  logic [1:0] step;
  logic [1:0] svc;

  // Instructions take four cycles; fetch halts while the forced call runs.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      step <= 2'h0;
      svc <= 2'h0;
      instr_last <= 1'b0;
      reti_exec <= 1'b0;
    end else begin
      step <= core_call.suppress_fetch ? 2'h0 : step + 2'h1;
      instr_last <= !core_call.suppress_fetch && step == 2'h2;
      svc <= core_call.in_service ? svc + 2'h1 : 2'h0;
      reti_exec <= core_call.in_service && svc == 2'h2 && !reti_exec;
    end
  end
endmodule
`default_nettype wire

// file: bench/vectored_interrupt_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_bench;
  logic core_clk;
  logic reset;
  vic_pkg::vic_bus_t bus;
  logic [7:0] reg_rdata;
  logic [31:0] int_req;
  logic instr_last;
  logic reti_exec;
  vic_pkg::vic_call_t core_call;
  logic irq;
  int bad_count;
  int checks_done;

  always #4 core_clk = ~core_clk;

  vic_ctrl uut (.core_clk(core_clk), .reset(reset), .bus(bus), .reg_rdata(reg_rdata),
    .int_req(int_req), .instr_last(instr_last), .reti_exec(reti_exec),
    .core_call(core_call), .irq(irq));
  vic_core_model u_core (.core_clk(core_clk), .reset(reset), .core_call(core_call),
    .instr_last(instr_last), .reti_exec(reti_exec));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    bus <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    bus <= '0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask

  task automatic pulse(input logic [31:0] m);
    @(posedge core_clk);
    int_req <= m;
    @(posedge core_clk);
    int_req <= '0;
  endtask

  // A call must show up within 60 cycles, or must not when want is low.
  task automatic wait_call(input logic [15:0] e, input logic want);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (n < 60 && core_call.call_start !== 1'b1);
    chk({15'h0000, core_call.call_start === 1'b1}, {15'h0000, want});
    if (want) chk(core_call.vector, e);
  endtask

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge core_clk);
    #1;
    chk({15'h0000, irq}, {15'h0000, e});
  endtask

  task automatic t_boot;
    wait_call(16'h0000, 1'b1);
    rd_chk(8'hAD, 8'h00);
    rd_chk(8'hC0, 8'h00);
  endtask

  task automatic t_latch;
    wr(8'hAD, 8'hFF);
    rd_chk(8'hAD, 8'h3F);
    pulse(32'h8000_0000);
    wait_call(16'h0000, 1'b0);
    rd_chk(8'hB3, 8'h80);
    wr(8'hB3, 8'h7F);
    rd_chk(8'hB3, 8'h00);
    pulse(32'h8000_0000);
    wr(8'hAE, 8'h01);
    wait_call(16'h00FB, 1'b1);
    rd_chk(8'hB3, 8'h00);
  endtask

  task automatic t_prio;
    wr(8'hAE, 8'h00);
    wr(8'hAD, 8'h01);
    pulse(32'hC000_0000);
    wr(8'hAE, 8'h01);
    wait_call(16'h00F3, 1'b1);
    rd_chk(8'hB7, 8'hF3);
    rd_chk(8'hB8, 8'h00);
    rd_chk(8'hB6, 8'h5F);
    wait_call(16'h0000, 1'b0);
    rd_chk(8'hB3, 8'h80);
    wr(8'hAD, 8'h02);
    wait_call(16'h00FB, 1'b1);
  endtask

  task automatic t_resv;
    wr(8'hA8, 8'h3F);
    wr(8'hAB, 8'h3F);
    pulse(32'h0080_0020);
    rd_chk(8'hB0, 8'h00);
    rd_chk(8'hB2, 8'h00);
    wait_call(16'h0000, 1'b0);
  endtask

  task automatic t_irq;
    wr(8'hB5, 8'h01);
    pulse(32'h0000_0001);
    wait_call(16'h0003, 1'b1);
    irq_chk(1'b1);
    wr(8'hB5, 8'h00);
    irq_chk(1'b0);
    wr(8'hB5, 8'h01);
    irq_chk(1'b1);
    rd_chk(8'hB4, 8'h03);
    wr(8'hB4, 8'h03);
    irq_chk(1'b0);
    rd_chk(8'hB4, 8'h00);
  endtask

  // A reset in mid-run drops latched requests and enables, then owes a boot call.
  task automatic t_reset;
    pulse(32'h4000_0000);
    rd_chk(8'hB3, 8'h40);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    wait_call(16'h0000, 1'b1);
    rd_chk(8'hAD, 8'h00);
    rd_chk(8'hB3, 8'h00);
  endtask

  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    bus = '0;
    int_req = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_boot();
    t_latch();
    t_prio();
    t_resv();
    t_irq();
    t_reset();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
